// file: verilog/drs_ref_select.sv
// The register addresses and the plain strobed port were chosen for this implementation.
`timescale 1ns/1ps
`include "drs_defines.svh"

module drs_ref_select
  import drs_pkg::*;
#(
  parameter int TIMER_W = 24
) (
  input  wire logic        clock,
  input  wire logic        resetn,
  input  wire logic [7:0]  reg_addr,
  input  wire logic [31:0] reg_wdata,
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  output logic      [31:0] reg_rdata,
  input  wire logic        gpio_ref_sel,
  input  wire logic        xo_clk_pin,
  input  wire logic [3:0]  mon_flags_zero,
  input  wire logic [3:0]  mon_flags_one,
  input  wire logic        freq_locked,
  input  wire logic        history_valid,
  output logic      [7:0]  status_pin_flags,
  output logic             ref_active,
  output logic             ref_selected,
  output drs_loop_t        loop_state,
  output logic             switch_event,
  output logic             phase_buildout,
  output logic             slew_active,
  output logic             slew_step,
  output logic      [15:0] slew_step_limit,
  output logic             crystal_input_loss_flag,
  output logic             crystal_valid
);

  if (TIMER_W < 4 || TIMER_W > 32) begin : g_bad_timer_w
    $error("TIMER_W out of range");
  end

  localparam int XO_MIN_CNT = (`DRS_XO_MIN_KHZ / 1000) * `DRS_XO_GATE_CYCLES
                              / (`DRS_CLK_KHZ / 1000);
  localparam int XO_MAX_CNT = (`DRS_XO_MAX_KHZ / 1000) * `DRS_XO_GATE_CYCLES
                              / (`DRS_CLK_KHZ / 1000);

  // Registers.
  logic [31:0] ctrl_q;
  logic [31:0] prio_q;
  logic [3:0]  mon_en_q [2];
  logic [TIMER_W-1:0] vtimer_q [2];
  logic [31:0] slew_q;

  drs_mode_t mode;
  assign mode = drs_mode_t'(ctrl_q[`DRS_CTRL_MODE_LSB +: 2]);

  function automatic logic [2:0] prio_of(input logic [31:0] p, input logic idx);
    prio_of = idx ? p[`DRS_PRIO_STRIDE +: 3] : p[2:0];
  endfunction

  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      ctrl_q      <= `DRS_CTRL_RESET;
      prio_q      <= `DRS_PRIO_RESET;
      mon_en_q[0] <= 4'h0;
      mon_en_q[1] <= 4'h0;
      vtimer_q[0] <= '0;
      vtimer_q[1] <= '0;
      slew_q      <= 32'h0000_0000;
    end else if (reg_wr) begin
      unique case (reg_addr)
        `DRS_ADDR_CTRL:    ctrl_q <= reg_wdata;
        `DRS_ADDR_PRIO:    prio_q <= reg_wdata & 32'h0000_0077;
        `DRS_ADDR_MON_EN0: mon_en_q[0] <= reg_wdata[3:0];
        `DRS_ADDR_MON_EN1: mon_en_q[1] <= reg_wdata[3:0];
        `DRS_ADDR_VTIMER0: vtimer_q[0] <= reg_wdata[TIMER_W-1:0];
        `DRS_ADDR_VTIMER1: vtimer_q[1] <= reg_wdata[TIMER_W-1:0];
        `DRS_ADDR_SLEW:    slew_q <= reg_wdata;
        default: ;
      endcase
    end
  end

  // Synchronisers for pins and monitor flags.
  logic [8:0] sync1_q;
  logic [8:0] sync2_q;
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      sync1_q <= 9'h000;
      sync2_q <= 9'h000;
    end else begin
      sync1_q <= {gpio_ref_sel, mon_flags_one, mon_flags_zero};
      sync2_q <= sync1_q;
    end
  end

  logic [3:0] flags [2];
  logic       gpio_sel;
  assign gpio_sel = sync2_q[8];

  genvar g;
  generate
    for (g = 0; g < 2; g++) begin : g_in
      assign flags[g] = sync2_q[4*g +: 4] & mon_en_q[g];
    end
  endgenerate

  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      status_pin_flags <= 8'h00;
    end else begin
      status_pin_flags <= {flags[1], flags[0]};
    end
  end

  // Validation timers.
  logic [TIMER_W-1:0] vcnt_q [2];
  logic [1:0]         qual_q;
  generate
    for (g = 0; g < 2; g++) begin : g_val
      always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
          vcnt_q[g] <= '0;
          qual_q[g] <= 1'b0;
        end else if (|flags[g]) begin
          vcnt_q[g] <= '0;
          qual_q[g] <= 1'b0;
        end else if (vcnt_q[g] >= vtimer_q[g]) begin
          qual_q[g] <= 1'b1;
        end else begin
          vcnt_q[g] <= vcnt_q[g] + 1'b1;
        end
      end
    end
  endgenerate

  // Best valid input by priority.
  logic [2:0] p0;
  logic [2:0] p1;
  logic       ok0;
  logic       ok1;
  logic       best_any;
  logic       best_idx;
  always_comb begin
    p0 = prio_of(prio_q, 1'b0);
    p1 = prio_of(prio_q, 1'b1);
    ok0 = qual_q[0] && (p0 != 3'h0);
    ok1 = qual_q[1] && (p1 != 3'h0);
    best_any = ok0 || ok1;
    if (ok0 && ok1) begin
      best_idx = (p1 < p0);
    end else begin
      best_idx = !ok0;
    end
  end

  logic man_idx;
  assign man_idx = ctrl_q[`DRS_CTRL_PIN_SEL_BIT] ? gpio_sel : ctrl_q[`DRS_CTRL_MAN_SEL_BIT];

  logic      sel_q;
  drs_loop_t loop_q;
  logic      sel_d;
  drs_loop_t loop_d;
  logic      cur_ok;
  drs_loop_t no_ref;

  always_comb begin
    cur_ok = qual_q[sel_q];
    no_ref = history_valid ? DRS_LOOP_HOLDOVER : DRS_LOOP_FREERUN;
    sel_d  = sel_q;
    loop_d = loop_q;
    unique case (mode)
      DRS_AUTO_REVERT: begin
        if (best_any) begin
          sel_d  = best_idx;
          loop_d = DRS_LOOP_LOCKED;
        end else begin
          loop_d = no_ref;
        end
      end
      DRS_AUTO_NONREVERT: begin
        if (loop_q == DRS_LOOP_LOCKED && cur_ok && prio_of(prio_q, sel_q) != 3'h0) begin
          loop_d = DRS_LOOP_LOCKED;
        end else if (best_any) begin
          sel_d  = best_idx;
          loop_d = DRS_LOOP_LOCKED;
        end else begin
          loop_d = no_ref;
        end
      end
      DRS_MAN_FALLBACK: begin
        if (qual_q[man_idx]) begin
          sel_d  = man_idx;
          loop_d = DRS_LOOP_LOCKED;
        end else if (best_any) begin
          sel_d  = best_idx;
          loop_d = DRS_LOOP_LOCKED;
        end else begin
          loop_d = no_ref;
        end
      end
      DRS_MAN_HOLDOVER: begin
        sel_d = man_idx;
        if (qual_q[man_idx]) begin
          loop_d = DRS_LOOP_LOCKED;
        end else begin
          loop_d = no_ref;
        end
      end
    endcase
  end

  logic acq_q;
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      sel_q        <= 1'b0;
      loop_q       <= DRS_LOOP_FREERUN;
      switch_event <= 1'b0;
      acq_q        <= 1'b0;
    end else begin
      sel_q        <= sel_d;
      loop_q       <= loop_d;
      switch_event <= (loop_q == DRS_LOOP_LOCKED) && (loop_d == DRS_LOOP_LOCKED)
                      && (sel_d != sel_q);
      acq_q        <= (loop_q != DRS_LOOP_LOCKED) && (loop_d == DRS_LOOP_LOCKED);
    end
  end

  assign ref_selected = sel_q;
  assign loop_state   = loop_q;
  assign ref_active   = (loop_q == DRS_LOOP_LOCKED);

  // Hitless switching control.
  logic        hitless;
  logic        cancel;
  logic        slew_en;
  logic [15:0] step_tmr_q;
  assign hitless = ctrl_q[`DRS_CTRL_HITLESS_BIT];
  assign cancel  = hitless && ctrl_q[`DRS_CTRL_CANCEL_BIT];
  assign slew_en = ctrl_q[`DRS_CTRL_SLEW_BIT];
  assign slew_step_limit = slew_q[15:0];

  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      phase_buildout <= 1'b0;
      slew_active    <= 1'b0;
    end else begin
      if (!cancel) begin
        phase_buildout <= 1'b0;
      end else if (switch_event && freq_locked && !slew_en) begin
        phase_buildout <= 1'b1;
      end else if (slew_en && slew_step) begin
        phase_buildout <= 1'b0;
      end
      if (!slew_en) begin
        slew_active <= 1'b0;
      end else if (acq_q || phase_buildout || (switch_event && (!freq_locked || cancel))) begin
        slew_active <= 1'b1;
      end else if (slew_step && !phase_buildout) begin
        slew_active <= 1'b0;
      end
    end
  end

  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      step_tmr_q <= 16'h0000;
      slew_step  <= 1'b0;
    end else if (!slew_active || step_tmr_q >= slew_q[31:`DRS_SLEW_TIMER_LSB]) begin
      step_tmr_q <= 16'h0000;
      slew_step  <= slew_active;
    end else begin
      step_tmr_q <= step_tmr_q + 16'h0001;
      slew_step  <= 1'b0;
    end
  end

  // Crystal coarse monitor: count crystal edges over a fixed gate.
  logic [2:0]  xo_sync_q;
  logic [15:0] gate_q;
  logic [15:0] xo_cnt_q;
  logic [15:0] xo_last_q;
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      xo_sync_q <= 3'b000;
      gate_q    <= 16'h0000;
      xo_cnt_q  <= 16'h0000;
      xo_last_q <= 16'h0000;
      crystal_input_loss_flag <= 1'b1;
    end else begin
      xo_sync_q <= {xo_sync_q[1:0], xo_clk_pin};
      if (gate_q == 16'(`DRS_XO_GATE_CYCLES - 1)) begin
        gate_q    <= 16'h0000;
        xo_cnt_q  <= 16'h0000;
        xo_last_q <= xo_cnt_q;
        crystal_input_loss_flag <= !((xo_cnt_q >= 16'(XO_MIN_CNT))
                                   && (xo_cnt_q <= 16'(XO_MAX_CNT)));
      end else begin
        gate_q <= gate_q + 16'h0001;
        if (xo_sync_q[1] && !xo_sync_q[2]) begin
          xo_cnt_q <= xo_cnt_q + 16'h0001;
        end
      end
    end
  end

  assign crystal_valid = ctrl_q[`DRS_CTRL_XO_BYP_BIT] || !crystal_input_loss_flag;

  // Register read port, data valid the cycle after the strobe.
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      reg_rdata <= 32'h0000_0000;
    end else if (reg_rd) begin
      unique case (reg_addr)
        `DRS_ADDR_CTRL:      reg_rdata <= ctrl_q;
        `DRS_ADDR_PRIO:      reg_rdata <= prio_q;
        `DRS_ADDR_MON_EN0:   reg_rdata <= {28'h0, mon_en_q[0]};
        `DRS_ADDR_MON_EN1:   reg_rdata <= {28'h0, mon_en_q[1]};
        `DRS_ADDR_VTIMER0:   reg_rdata <= 32'(vtimer_q[0]);
        `DRS_ADDR_VTIMER1:   reg_rdata <= 32'(vtimer_q[1]);
        `DRS_ADDR_SLEW:      reg_rdata <= slew_q;
        `DRS_ADDR_STATUS:    reg_rdata <= {23'h0, crystal_valid, crystal_input_loss_flag,
                                           slew_active, phase_buildout, qual_q,
                                           loop_q, sel_q};
        `DRS_ADDR_MON_STAT:  reg_rdata <= {28'h0, flags[sel_q]};
        `DRS_ADDR_XO_PERIOD: reg_rdata <= {16'h0, xo_last_q};
        `DRS_ADDR_ID:        reg_rdata <= `DRS_ID_VALUE;
        default:             reg_rdata <= 32'h0000_0000;
      endcase
    end else begin
      reg_rdata <= 32'h0000_0000;
    end
  end

endmodule

// file: inc/drs_defines.svh
`ifndef DRS_DEFINES_SVH
`define DRS_DEFINES_SVH

// Register word addresses (byte address = 4 * index not used; plain word index).
`define DRS_ADDR_CTRL        8'h00
`define DRS_ADDR_PRIO        8'h01
`define DRS_ADDR_MON_EN0     8'h02
`define DRS_ADDR_MON_EN1     8'h03
`define DRS_ADDR_VTIMER0     8'h04
`define DRS_ADDR_VTIMER1     8'h05
`define DRS_ADDR_SLEW        8'h06
`define DRS_ADDR_STATUS      8'h07
`define DRS_ADDR_MON_STAT    8'h08
`define DRS_ADDR_XO_PERIOD   8'h09
`define DRS_ADDR_ID          8'h0A

// Control register fields.
`define DRS_CTRL_MODE_LSB    0
`define DRS_CTRL_MAN_SEL_BIT 2
`define DRS_CTRL_PIN_SEL_BIT 3
`define DRS_CTRL_CANCEL_BIT  4
`define DRS_CTRL_SLEW_BIT    5
`define DRS_CTRL_XO_BYP_BIT  6
`define DRS_CTRL_HITLESS_BIT 7
`define DRS_CTRL_RESET       32'h0000_0000

// Priority register: input zero in bits 2:0, input one in bits 6:4.
`define DRS_PRIO_STRIDE      4
`define DRS_PRIO_RESET       32'h0000_0021

// Monitor enable bits per input.
`define DRS_MON_FREQ_BIT     0
`define DRS_MON_MISS_BIT     1
`define DRS_MON_RUNT_BIT     2
`define DRS_MON_PPS_BIT      3

// Slew register: step limit bits 15:0, step timer bits 31:16.
`define DRS_SLEW_TIMER_LSB   16

// Crystal window limits in kHz and the counting reference.
`define DRS_XO_MIN_KHZ       9000
`define DRS_XO_MAX_KHZ       160000
`define DRS_CLK_KHZ          50000
`define DRS_XO_GATE_CYCLES   1024
// Arbitrary identification value with no meaning beyond this block.
`define DRS_ID_VALUE         32'h0000_5A01

`endif

// file: inc/drs_pkg.sv
package drs_pkg;

  typedef enum logic [1:0] {
    DRS_AUTO_REVERT,
    DRS_AUTO_NONREVERT,
    DRS_MAN_FALLBACK,
    DRS_MAN_HOLDOVER
  } drs_mode_t;

  typedef enum logic [1:0] {
    DRS_LOOP_FREERUN,
    DRS_LOOP_HOLDOVER,
    DRS_LOOP_LOCKED
  } drs_loop_t;

  typedef struct packed {
    logic [7:0]  addr;
    logic [31:0] wdata;
    logic        wr;
    logic        rd;
  } drs_bus_req_t;

  typedef struct packed {
    logic [1:0] flag;
    logic       pps;
  } drs_dummy_t;

  typedef struct packed {
    logic freq;
    logic miss;
    logic runt;
    logic pps;
  } drs_mon_t;

endpackage

// file: tb/drs_xo_src.sv
`timescale 1ns/1ps
module drs_xo_src (
  input  wire logic       clock,
  input  wire logic       resetn,
  input  wire logic [3:0] half,
  output logic            xo_clk_pin
);
  logic [3:0] cnt_q;

  // crystal rate source
  // A half period of zero models a stopped crystal, far below the valid window.
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      cnt_q      <= 4'h0;
      xo_clk_pin <= 1'b0;
    end else if (half != 4'h0) begin
      if (cnt_q + 4'h1 >= half) begin
        cnt_q      <= 4'h0;
        xo_clk_pin <= ~xo_clk_pin;
      end else begin
        cnt_q <= cnt_q + 4'h1;
      end
    end
  end
endmodule

// file: tb/drs_ref_select_sva.sv
`timescale 1ns/1ps
module drs_ref_select_sva
  import drs_pkg::*;
(
  input wire logic        clock,
  input wire logic        resetn,
  input wire logic [7:0]  reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic        reg_wr,
  input wire logic        reg_rd,
  input wire logic [31:0] reg_rdata,
  input wire logic        xo_clk_pin,
  input wire logic [3:0]  mon_flags_zero,
  input wire logic [3:0]  mon_flags_one,
  input wire logic [7:0]  status_pin_flags,
  input wire logic        ref_selected,
  input wire drs_loop_t   loop_state,
  input wire logic        switch_event,
  input wire logic [15:0] slew_step_limit,
  input wire logic        crystal_input_loss_flag,
  input wire logic        crystal_valid
);
  logic [11:0] still_q;
  logic        xo_last_q;

  default clocking cb @(posedge clock); endclocking
  default disable iff (!resetn);

  // Counts cycles since the crystal pin last moved.
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      still_q   <= 12'h000;
      xo_last_q <= 1'b0;
    end else begin
      xo_last_q <= xo_clk_pin;
      if (xo_clk_pin != xo_last_q) begin
        still_q <= 12'h000;
      end else if (still_q != 12'hFFF) begin
        still_q <= still_q + 12'h001;
      end
    end
  end

  property p_xo_valid;
    !crystal_input_loss_flag |-> crystal_valid;
  endproperty
  a_xo_valid: assert property (p_xo_valid) else $error("crystal valid low");
  property p_xo_lost;
    still_q >= 12'h898 |-> crystal_input_loss_flag;
  endproperty
  a_xo_lost: assert property (p_xo_lost) else $error("stopped crystal not lost");
  property p_pins0;
    mon_flags_zero == 4'h0 [*4] |-> status_pin_flags[3:0] == 4'h0;
  endproperty
  a_pins0: assert property (p_pins0) else $error("input zero pin flag");
  property p_pins1;
    mon_flags_one == 4'h0 [*4] |-> status_pin_flags[7:4] == 4'h0;
  endproperty
  a_pins1: assert property (p_pins1) else $error("input one pin flag");
  property p_slew_wr;
    reg_wr && reg_addr == 8'h06 |=> slew_step_limit == $past(reg_wdata[15:0]);
  endproperty
  a_slew_wr: assert property (p_slew_wr) else $error("step limit not written");
  property p_slew_hold;
    !(reg_wr && reg_addr == 8'h06) |=> $stable(slew_step_limit);
  endproperty
  a_slew_hold: assert property (p_slew_hold) else $error("step limit moved");
  property p_stat;
    reg_rd && reg_addr == 8'h07 |=> reg_rdata[2:0] == {$past(loop_state), $past(ref_selected)}
      && reg_rdata[7] == $past(crystal_input_loss_flag);
  endproperty
  a_stat: assert property (p_stat) else $error("status word wrong");
  property p_sw_pulse;
    switch_event |=> !switch_event;
  endproperty
  a_sw_pulse: assert property (p_sw_pulse) else $error("switch pulse too long");
  property p_sw_cause;
    switch_event |-> $past(loop_state) == DRS_LOOP_LOCKED && loop_state == DRS_LOOP_LOCKED
      && ref_selected != $past(ref_selected);
  endproperty
  a_sw_cause: assert property (p_sw_cause) else $error("switch without reselect");

  c_switch: cover property (switch_event);
  c_hold: cover property (loop_state == DRS_LOOP_HOLDOVER);
  c_bypass: cover property (crystal_valid && crystal_input_loss_flag);
endmodule

bind drs_ref_select drs_ref_select_sva i_sva (
  .clock, .resetn, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .xo_clk_pin,
  .mon_flags_zero, .mon_flags_one, .status_pin_flags, .ref_selected, .loop_state,
  .switch_event, .slew_step_limit, .crystal_input_loss_flag, .crystal_valid
);

// file: tb/drs_ref_select_tb.sv
`timescale 1ns/1ps
module drs_ref_select_tb;
  import drs_pkg::*;
  logic        clock, resetn, reg_wr, reg_rd, gpio_ref_sel, xo_clk_pin;
  logic        freq_locked, history_valid, ref_active, ref_selected, switch_event;
  logic        phase_buildout, slew_active, slew_step, crystal_input_loss_flag;
  logic        crystal_valid;
  logic [7:0]  reg_addr, status_pin_flags;
  logic [31:0] reg_wdata, reg_rdata, v;
  logic [3:0]  mon_flags_zero, mon_flags_one, xo_half;
  logic [15:0] slew_step_limit;
  drs_loop_t   loop_state;
  int          bad_count, n_compared, cyc;
  int          n_sw, n_step, sw_base;

  drs_ref_select i_dut (.clock, .resetn, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
    .gpio_ref_sel, .xo_clk_pin, .mon_flags_zero, .mon_flags_one, .freq_locked,
    .history_valid, .status_pin_flags, .ref_active, .ref_selected, .loop_state,
    .switch_event, .phase_buildout, .slew_active, .slew_step, .slew_step_limit,
    .crystal_input_loss_flag, .crystal_valid);
  drs_xo_src i_xo (.clock, .resetn, .half(xo_half), .xo_clk_pin);

  initial begin
    clock = 1'b0;
    forever #10 clock = ~clock;
  end

  task automatic wt(input int n);
    repeat (n) @(posedge clock);
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clock);
    reg_wr    <= 1'b1;
    reg_addr  <= a;
    reg_wdata <= d;
    @(posedge clock);
    reg_wr <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a);
    @(posedge clock);
    reg_rd   <= 1'b1;
    reg_addr <= a;
    @(posedge clock);
    reg_rd <= 1'b0;
    #1 v = reg_rdata;
  endtask

  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    n_compared++;
    if (g !== e) begin
      bad_count++;
      $display("wrong value at %0t: got %h want %h", $time, g, e);
    end
  endtask

  task automatic close_out;
    $display("compared %0d mismatches %0d", n_compared, bad_count);
    if (bad_count == 0 && n_compared > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  always @(posedge clock) begin
    cyc++;
    if (switch_event === 1'b1) begin
      n_sw++;
    end
    if (slew_step === 1'b1) begin
      n_step++;
    end
    if (cyc == 20000) begin
      bad_count++;
      $display("wrong value at %0t: run timed out", $time);
      close_out();
    end
  end

  initial begin
    resetn         = 1'b0;
    reg_wr         = 1'b0;
    reg_rd         = 1'b0;
    reg_addr       = 8'h00;
    reg_wdata      = 32'h0;
    gpio_ref_sel   = 1'b0;
    mon_flags_zero = 4'h0;
    mon_flags_one  = 4'h0;
    freq_locked    = 1'b1;
    history_valid  = 1'b1;
    xo_half        = 4'h2;
    wt(8);
    resetn <= 1'b1;
    rd(8'h01);
    chk(v, 32'h21);
    wr(8'h02, 32'h1);
    wr(8'h03, 32'h1);
    wr(8'h04, 32'h10);
    wr(8'h05, 32'h10);
    wr(8'h01, 32'h11);
    wt(2200);
    rd(8'h07);
    chk(v, 32'h11C);
    wr(8'h01, 32'h12);
    wt(4);
    chk(ref_selected, 1'b1);
    wr(8'h00, 32'h1);
    wr(8'h01, 32'h21);
    wt(4);
    chk(ref_selected, 1'b1);
    mon_flags_one <= 4'h1;
    wt(8);
    chk(ref_selected, 1'b0);
    chk(status_pin_flags, 8'h10);
    rd(8'h08);
    chk(v, 32'h0);
    mon_flags_one  <= 4'h0;
    mon_flags_zero <= 4'h2;
    wt(8);
    chk(status_pin_flags, 8'h00);
    chk(loop_state, DRS_LOOP_LOCKED);
    mon_flags_zero <= 4'h0;
    wr(8'h00, 32'h7);
    wt(40);
    chk(ref_selected, 1'b1);
    mon_flags_one <= 4'h1;
    wt(8);
    chk({loop_state, ref_selected}, {DRS_LOOP_HOLDOVER, 1'b1});
    mon_flags_one <= 4'h0;
    wt(40);
    chk(loop_state, DRS_LOOP_LOCKED);
    history_valid <= 1'b0;
    mon_flags_one <= 4'h1;
    wt(8);
    chk(loop_state, DRS_LOOP_FREERUN);
    history_valid <= 1'b1;
    wr(8'h00, 32'h6);
    wt(8);
    chk({loop_state, ref_selected}, {DRS_LOOP_LOCKED, 1'b0});
    mon_flags_one <= 4'h0;
    gpio_ref_sel  <= 1'b1;
    wr(8'h00, 32'hA);
    wt(40);
    chk(ref_selected, 1'b1);
    wr(8'h06, 32'h0004_1234);
    wt(2);
    chk(slew_step_limit, 16'h1234);
    rd(8'h20);
    chk(v, 32'h0);
    wr(8'h00, 32'h9A);
    sw_base = n_sw;
    gpio_ref_sel <= 1'b0;
    wt(8);
    chk(n_sw - sw_base, 32'h1);
    chk({ref_selected, phase_buildout}, 2'b01);
    wr(8'h00, 32'h0A);
    wt(2);
    chk(phase_buildout, 1'b0);
    wr(8'h00, 32'h9A);
    freq_locked  <= 1'b0;
    gpio_ref_sel <= 1'b1;
    wt(8);
    chk({ref_selected, phase_buildout}, 2'b10);
    freq_locked  <= 1'b1;
    gpio_ref_sel <= 1'b0;
    wt(8);
    chk({ref_selected, phase_buildout}, 2'b01);
    wr(8'h00, 32'hBA);
    wt(2);
    chk({slew_active, phase_buildout}, 2'b11);
    wt(20);
    chk({slew_active, phase_buildout}, 2'b00);
    chk(n_step, 32'h2);
    mon_flags_zero <= 4'h1;
    mon_flags_one  <= 4'h1;
    wt(8);
    chk(loop_state, DRS_LOOP_HOLDOVER);
    mon_flags_zero <= 4'h0;
    mon_flags_one  <= 4'h0;
    wt(24);
    chk({slew_active, ref_active}, 2'b11);
    xo_half <= 4'h0;
    wt(2200);
    chk({crystal_input_loss_flag, crystal_valid}, 2'b10);
    wr(8'h00, 32'h4A);
    wt(2);
    chk({crystal_input_loss_flag, crystal_valid}, 2'b11);
    close_out();
  end
endmodule
